// >>> logic/mioc_consts.vh
// constants for the motion module io command unit
`ifndef MIOC_CONSTS_VH
`define MIOC_CONSTS_VH

// addresses, values arbitrary defaults
`define MIOC_ADDR_MODULE 8'h01
`define MIOC_ADDR_HOST 8'h02

`define MIOC_FRAME_LAST 4'h8
`define MIOC_REPLY_LAST 4'h8

`define MIOC_INSTR_RESTORE 8'h0C
`define MIOC_INSTR_HOMING 8'h0D
`define MIOC_INSTR_SETOUT 8'h0E
`define MIOC_INSTR_READ 8'h0F

`define MIOC_ST_BAD_CSUM 8'h01
`define MIOC_ST_BAD_INSTR 8'h02
`define MIOC_ST_BAD_TYPE 8'h03
`define MIOC_ST_BAD_VALUE 8'h04
`define MIOC_ST_OK 8'h64

`define MIOC_BANK_0 8'h00
`define MIOC_BANK_1 8'h01
`define MIOC_BANK_2 8'h02

`define MIOC_HOME_START 8'h00
`define MIOC_HOME_STOP 8'h01
`define MIOC_HOME_STATUS 8'h02

`define MIOC_PORT_0 8'h00
`define MIOC_PORT_1 8'h01
`define MIOC_PORT_4 8'h04
`define MIOC_PORT_VOLT 8'h08
`define MIOC_PORT_TEMP 8'h09
`define MIOC_PORT_ALL 8'hFF
`define MIOC_NUM_INPUTS 8'h05

`define MIOC_VAL_FROM_ACC 32'hFFFF_FFFF
`define MIOC_VAL_MAX_BIT 32'h0000_0001
`define MIOC_VAL_MAX_VEC 32'h0000_00FF
`define MIOC_HOME_ACTIVE 32'h0000_0001

`define MIOC_REG_CTRL 4'h0
`define MIOC_REG_ACC 4'h4
`define MIOC_REG_IO 4'h8
`define MIOC_REG_ERRCNT 4'hC

`define MIOC_RST_PULLUP 1'b1

`endif

// >>> logic/mioc_reply_tx.v
// reply frame serialiser with checksum
`timescale 1ns/1ps
`include "mioc_consts.vh"

module mioc_reply_tx (
  input wire ref_clk,
  input wire nrst,
  input wire start,
  input wire [7:0] status,
  input wire [7:0] instr,
  input wire [31:0] value,
  input wire tx_ready,
  output reg [7:0] tx_data,
  output reg tx_valid,
  output reg done
);

  reg [7:0] byte_mem [1:8];
  reg [3:0] idx_reg;
  wire [7:0] csum;

  assign csum = `MIOC_ADDR_HOST + `MIOC_ADDR_MODULE + status + instr +
                value[31:24] + value[23:16] + value[15:8] + value[7:0];

  always @(posedge ref_clk) begin
    if (!nrst) begin
      tx_data <= 8'h00;
      tx_valid <= 1'b0;
      done <= 1'b0;
      idx_reg <= 4'h0;
    end else begin
      done <= 1'b0;
      if (start && !tx_valid) begin
        byte_mem[1] <= `MIOC_ADDR_MODULE;
        byte_mem[2] <= status;
        byte_mem[3] <= instr;
        byte_mem[4] <= value[31:24];
        byte_mem[5] <= value[23:16];
        byte_mem[6] <= value[15:8];
        byte_mem[7] <= value[7:0];
        byte_mem[8] <= csum;
        tx_data <= `MIOC_ADDR_HOST;
        tx_valid <= 1'b1;
        idx_reg <= 4'h1;
      end else if (tx_valid && tx_ready) begin
        if (idx_reg > `MIOC_REPLY_LAST) begin
          tx_valid <= 1'b0;
          done <= 1'b1;
        end else begin
          tx_data <= byte_mem[idx_reg];
          idx_reg <= idx_reg + 4'h1;
        end
      end
    end
  end

endmodule // mioc_reply_tx

// >>> logic/mioc_core.v
// command frame receiver, executor and register port
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "mioc_consts.vh"

module mioc_core (
  input wire ref_clk,
  input wire nrst,
  input wire [7:0] rx_data,
  input wire rx_valid,
  output reg rx_ready,
  output wire [7:0] tx_data,
  output wire tx_valid,
  input wire tx_ready,
  input wire [4:0] gen_in,
  input wire [11:0] adc_in_a,
  input wire [11:0] adc_in_e,
  input wire [15:0] supply_dv,
  input wire [15:0] temp_c,
  input wire homing_busy,
  output reg homing_start,
  output reg homing_stop,
  output reg restore_req,
  output reg [7:0] restore_index,
  output reg general_output_a,
  output reg general_output_b,
  output reg pullup_en,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata
);

  localparam [1:0] ST_RX = 2'b00;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_SEND = 2'b10;

  reg [1:0] state_reg;
  reg [3:0] cnt_reg;
  reg [7:0] sum_reg;
  reg [7:0] frame_mem [0:8];
  reg standalone_reg;
  reg [31:0] acc_reg;
  reg [15:0] errcnt_reg;
  reg tx_start_reg;
  reg [7:0] rep_status_reg;
  reg [7:0] rep_instr_reg;
  reg [31:0] rep_value_reg;
  wire tx_done;

  wire [7:0] f_addr;
  wire [7:0] f_instr;
  wire [7:0] f_type;
  wire [7:0] f_bank;
  wire [31:0] f_value;
  wire cs_ok;

  assign f_addr = frame_mem[0];
  assign f_instr = frame_mem[1];
  assign f_type = frame_mem[2];
  assign f_bank = frame_mem[3];
  assign f_value = {frame_mem[4], frame_mem[5], frame_mem[6], frame_mem[7]};
  assign cs_ok = (sum_reg == frame_mem[8]);

  // execution decode
  reg [7:0] ex_status;
  reg [31:0] ex_value;
  reg ex_restore;
  reg ex_hstart;
  reg ex_hstop;
  reg ex_set_out;
  reg ex_lvl_a;
  reg ex_lvl_b;
  reg ex_set_pu;
  reg ex_read;
  reg ex_acc_force;
  reg [7:0] ex_vec;

  always @* begin
    ex_status = `MIOC_ST_OK;
    ex_value = 32'h0000_0000;
    ex_restore = 1'b0;
    ex_hstart = 1'b0;
    ex_hstop = 1'b0;
    ex_set_out = 1'b0;
    ex_lvl_a = general_output_a;
    ex_lvl_b = general_output_b;
    ex_set_pu = 1'b0;
    ex_read = 1'b0;
    ex_acc_force = 1'b0;
    ex_vec = 8'h00;
    if (!cs_ok) begin
      ex_status = `MIOC_ST_BAD_CSUM;
    end else begin
      case (f_instr)
        `MIOC_INSTR_RESTORE: begin
          if (f_bank == `MIOC_BANK_2) begin
            ex_restore = 1'b1;
          end else begin
            ex_status = `MIOC_ST_BAD_VALUE;
          end
        end
        `MIOC_INSTR_HOMING: begin
          if (f_bank != `MIOC_BANK_0) begin
            ex_status = `MIOC_ST_BAD_VALUE;
          end else begin
            case (f_type)
              `MIOC_HOME_START: ex_hstart = 1'b1;
              `MIOC_HOME_STOP: ex_hstop = 1'b1;
              `MIOC_HOME_STATUS: begin
                ex_value = homing_busy ? `MIOC_HOME_ACTIVE :
                           32'h0000_0000;
              end
              default: ex_status = `MIOC_ST_BAD_TYPE;
            endcase
          end
        end
        `MIOC_INSTR_SETOUT: begin
          if (f_bank == `MIOC_BANK_2) begin
            case (f_type)
              `MIOC_PORT_0: begin
                if (f_value > `MIOC_VAL_MAX_BIT) begin
                  ex_status = `MIOC_ST_BAD_VALUE;
                end else begin
                  ex_set_out = 1'b1;
                  ex_lvl_a = f_value[0];
                end
              end
              `MIOC_PORT_1: begin
                if (f_value > `MIOC_VAL_MAX_BIT) begin
                  ex_status = `MIOC_ST_BAD_VALUE;
                end else begin
                  ex_set_out = 1'b1;
                  ex_lvl_b = f_value[0];
                end
              end
              `MIOC_PORT_ALL: begin
                if (f_value == `MIOC_VAL_FROM_ACC) begin
                  ex_vec = acc_reg[7:0];
                  ex_set_out = 1'b1;
                end else if (f_value > `MIOC_VAL_MAX_VEC) begin
                  ex_status = `MIOC_ST_BAD_VALUE;
                end else begin
                  ex_vec = f_value[7:0];
                  ex_set_out = 1'b1;
                end
                ex_lvl_a = ex_set_out ? ex_vec[0] : general_output_a;
                ex_lvl_b = ex_set_out ? ex_vec[1] : general_output_b;
              end
              default: ex_status = `MIOC_ST_BAD_TYPE;
            endcase
          end else if (f_bank == `MIOC_BANK_0) begin
            if (f_type != `MIOC_PORT_0) begin
              ex_status = `MIOC_ST_BAD_TYPE;
            end else if (f_value > `MIOC_VAL_MAX_BIT) begin
              ex_status = `MIOC_ST_BAD_VALUE;
            end else begin
              ex_set_pu = 1'b1;
            end
          end else begin
            ex_status = `MIOC_ST_BAD_VALUE;
          end
        end
        `MIOC_INSTR_READ: begin
          case (f_bank)
            `MIOC_BANK_0: begin
              if (f_type < `MIOC_NUM_INPUTS) begin
                ex_value = {31'h0000_0000, gen_in[f_type[2:0]]};
                ex_read = 1'b1;
              end else if (f_type == `MIOC_PORT_ALL) begin
                ex_value = {27'h000_0000, gen_in};
                ex_read = 1'b1;
                ex_acc_force = 1'b1;
              end else begin
                ex_status = `MIOC_ST_BAD_TYPE;
              end
            end
            `MIOC_BANK_1: begin
              ex_read = 1'b1;
              case (f_type)
                `MIOC_PORT_0: ex_value = {20'h0_0000, adc_in_a};
                `MIOC_PORT_4: ex_value = {20'h0_0000, adc_in_e};
                `MIOC_PORT_VOLT: ex_value = {16'h0000, supply_dv};
                `MIOC_PORT_TEMP: ex_value = {{16{temp_c[15]}}, temp_c};
                default: begin
                  ex_read = 1'b0;
                  ex_status = `MIOC_ST_BAD_TYPE;
                end
              endcase
            end
            `MIOC_BANK_2: begin
              ex_read = 1'b1;
              case (f_type)
                `MIOC_PORT_0: ex_value = {31'h0000_0000, general_output_a};
                `MIOC_PORT_1: ex_value = {31'h0000_0000, general_output_b};
                default: begin
                  ex_read = 1'b0;
                  ex_status = `MIOC_ST_BAD_TYPE;
                end
              endcase
            end
            default: ex_status = `MIOC_ST_BAD_VALUE;
          endcase
        end
        default: ex_status = `MIOC_ST_BAD_INSTR;
      endcase
    end
  end

  // frame reception and execution sequencing
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg <= ST_RX;
      cnt_reg <= 4'h0;
      sum_reg <= 8'h00;
      rx_ready <= 1'b1;
      tx_start_reg <= 1'b0;
      rep_status_reg <= 8'h00;
      rep_instr_reg <= 8'h00;
      rep_value_reg <= 32'h0000_0000;
      homing_start <= 1'b0;
      homing_stop <= 1'b0;
      restore_req <= 1'b0;
      restore_index <= 8'h00;
      general_output_a <= 1'b0;
      general_output_b <= 1'b0;
      pullup_en <= `MIOC_RST_PULLUP;
      acc_reg <= 32'h0000_0000;
      errcnt_reg <= 16'h0000;
    end else begin
      homing_start <= 1'b0;
      homing_stop <= 1'b0;
      restore_req <= 1'b0;
      tx_start_reg <= 1'b0;
      if (reg_wr && reg_addr == `MIOC_REG_ACC) begin
        acc_reg <= reg_wdata;
      end
      case (state_reg)
        ST_RX: begin
          if (rx_valid && rx_ready) begin
            frame_mem[cnt_reg] <= rx_data;
            if (cnt_reg == `MIOC_FRAME_LAST) begin
              rx_ready <= 1'b0;
              cnt_reg <= 4'h0;
              state_reg <= ST_EXEC;
            end else begin
              sum_reg <= sum_reg + rx_data;
              cnt_reg <= cnt_reg + 4'h1;
            end
          end
        end
        ST_EXEC: begin
          sum_reg <= 8'h00;
          if (f_addr != `MIOC_ADDR_MODULE) begin
            rx_ready <= 1'b1;
            state_reg <= ST_RX;
          end else begin
            rep_status_reg <= ex_status;
            rep_instr_reg <= f_instr;
            rep_value_reg <= ex_value;
            tx_start_reg <= 1'b1;
            state_reg <= ST_SEND;
            if (!cs_ok) begin
              errcnt_reg <= errcnt_reg + 16'h0001;
            end
            if (ex_restore) begin
              restore_req <= 1'b1;
              restore_index <= f_type;
            end
            homing_start <= ex_hstart;
            homing_stop <= ex_hstop;
            if (ex_set_out) begin
              general_output_a <= ex_lvl_a;
              general_output_b <= ex_lvl_b;
            end
            if (ex_set_pu) begin
              pullup_en <= f_value[0];
            end
            if (ex_read && (standalone_reg || ex_acc_force)) begin
              acc_reg <= ex_value;
            end
          end
        end
        ST_SEND: begin
          if (tx_done) begin
            rx_ready <= 1'b1;
            state_reg <= ST_RX;
          end
        end
        default: begin
          rx_ready <= 1'b1;
          state_reg <= ST_RX;
        end
      endcase
    end
  end

  // register port, read data valid only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (!nrst) begin
      standalone_reg <= 1'b0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && reg_addr == `MIOC_REG_CTRL) begin
        standalone_reg <= reg_wdata[0];
      end
      if (reg_rd) begin
        case (reg_addr)
          `MIOC_REG_CTRL: reg_rdata <= {31'h0000_0000, standalone_reg};
          `MIOC_REG_ACC: reg_rdata <= acc_reg;
          `MIOC_REG_IO: reg_rdata <= {28'h000_0000, homing_busy, pullup_en,
                                      general_output_b, general_output_a};
          `MIOC_REG_ERRCNT: reg_rdata <= {16'h0000, errcnt_reg};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  mioc_reply_tx u_reply (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(tx_start_reg),
    .status(rep_status_reg),
    .instr(rep_instr_reg),
    .value(rep_value_reg),
    .tx_ready(tx_ready),
    .tx_data(tx_data),
    .tx_valid(tx_valid),
    .done(tx_done)
  );

endmodule // mioc_core

// >>> sim/mioc_core_monitor.sv
// assertion checker for the command unit ports
`timescale 1ns/1ps
`include "mioc_consts.vh"
module mioc_core_monitor (
  input wire ref_clk,
  input wire nrst,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  input wire tx_ready,
  input wire homing_start,
  input wire homing_stop,
  input wire restore_req,
  input wire general_output_a,
  input wire pullup_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  reg [3:0] n_reg;
  reg [7:0] sum_reg;
  wire take = tx_valid && tx_ready;
  // reply byte position and running sum
  always @(posedge ref_clk) begin
    if (!nrst || (take && n_reg == 4'h8)) begin
      n_reg <= 4'h0;
      sum_reg <= 8'h00;
    end else if (take) begin
      n_reg <= n_reg + 4'h1;
      sum_reg <= sum_reg + tx_data;
    end
  end
  sequence s_tail;
    !tx_valid ##1 rx_ready;
  endsequence
  AST_PULLUP_RST: assert property (
    $rose(nrst) |-> pullup_en && !general_output_a)
    else $error("pull-up or output not at reset level");
  AST_TX_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte not held");
  AST_RX_BLOCK: assert property (
    tx_valid |-> !rx_ready) else $error("receiving during reply");
  AST_REPLY_HOST: assert property (
    take && n_reg == 4'h0 |-> tx_data == `MIOC_ADDR_HOST)
    else $error("first reply byte wrong");
  AST_REPLY_SUM: assert property (
    take && n_reg == 4'h8 |-> tx_data == sum_reg)
    else $error("reply checksum wrong");
  AST_REPLY_TAIL: assert property (
    take && n_reg == 4'h8 |=> s_tail) else $error("reply end wrong");
  AST_HOME_PULSE: assert property (
    homing_start |=> !homing_start && !homing_stop)
    else $error("homing start not one pulse");
  AST_RESTORE_PULSE: assert property (
    restore_req |=> !restore_req) else $error("restore not one pulse");
  AST_OUT_QUIET: assert property (
    $changed(general_output_a) || $changed(pullup_en) |-> !rx_ready)
    else $error("output moved outside a command");
endmodule // mioc_core_monitor

bind mioc_core mioc_core_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .homing_start(homing_start),
  .homing_stop(homing_stop), .restore_req(restore_req),
  .general_output_a(general_output_a), .pullup_en(pullup_en));

// >>> sim/mioc_host_model.sv
// host side model: sends command frames, collects replies
`timescale 1ns/1ps
module mioc_host_model (
  input wire ref_clk,
  input wire rx_ready,
  input wire [7:0] tx_data,
  input wire tx_valid,
  output reg [7:0] rx_data,
  output reg rx_valid,
  output reg tx_ready
);
  reg [7:0] rep [0:8];
  reg slow = 1'b0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  task send(input [7:0] tgt, ins, typ, bnk, input [31:0] v,
    input [7:0] err);
    reg [71:0] f;
    integer i;
    begin
      f = {tgt, ins, typ, bnk, v, 8'h00};
      for (i = 1; i < 9; i = i + 1)
        f[7:0] = f[7:0] + f[8*i +: 8];
      f[7:0] = f[7:0] ^ err;
      for (i = 8; i >= 0; i = i - 1) begin
        rx_data <= f[8*i +: 8];
        rx_valid <= 1'b1;
        @(posedge ref_clk);
        while (!rx_ready) @(posedge ref_clk);
      end
      rx_valid <= 1'b0;
      rx_data <= ~f[7:0];
    end
  endtask
  task recv;
    integer i;
    begin
      for (i = 0; i < 9; i = i + 1) begin
        if (slow) begin
          tx_ready <= 1'b0;
          repeat (2) @(posedge ref_clk);
        end
        tx_ready <= 1'b1;
        @(posedge ref_clk);
        while (!tx_valid) @(posedge ref_clk);
        rep[i] = tx_data;
      end
      tx_ready <= 1'b0;
    end
  endtask
endmodule // mioc_host_model

// >>> sim/testbench.sv
// self-checking bench for the command unit
`timescale 1ns/1ps
`include "mioc_consts.vh"
module testbench;
  localparam [39:0] sp = 40'h00_0100_FFFF;
  localparam [39:0] sv = 40'h01_0100_02FD;
  localparam [9:0] se = 10'b01_11_10_10_01;
  localparam [127:0] av = {32'h0000_012E, 32'h0000_0FFF,
    32'h0000_00F0, 32'hFFFF_FFFB};
  localparam [31:0] vx = 32'hxxxx_xxxx;
  reg ref_clk = 1'b0;
  reg nrst = 1'b0;
  reg [4:0] gen_in = 5'h16;
  reg homing_busy = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0000_0000;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  wire [7:0] rx_data, tx_data, rst_idx;
  wire rx_valid, rx_ready, tx_valid, tx_ready, h_start, h_stop, rst_req;
  wire out_a, out_b, pullup_en;
  wire [31:0] reg_rdata;
  reg [31:0] r;
  integer bad_count = 0, cmp_count = 0, cyc = 0, i;
  integer n_start = 0, n_stop = 0, n_rest = 0;
  mioc_core dut (.ref_clk(ref_clk), .nrst(nrst), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .gen_in(gen_in),
    .adc_in_a(12'h12E), .adc_in_e(12'hFFF), .supply_dv(16'h00F0),
    .temp_c(16'hFFFB), .homing_busy(homing_busy), .homing_start(h_start),
    .homing_stop(h_stop), .restore_req(rst_req), .restore_index(rst_idx),
    .general_output_a(out_a), .general_output_b(out_b),
    .pullup_en(pullup_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  mioc_host_model u_host (.ref_clk(ref_clk), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_ready(tx_ready));
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    n_start = n_start + h_start;
    n_stop = n_stop + h_stop;
    n_rest = n_rest + rst_req;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task cmd(input [7:0] ins, typ, bnk, input [31:0] v, input [7:0] st,
    input [31:0] ev);
    begin
      u_host.send(`MIOC_ADDR_MODULE, ins, typ, bnk, v, 8'h00);
      u_host.recv;
      chk("target", `MIOC_ADDR_MODULE, u_host.rep[1]);
      chk("status", st, u_host.rep[2]);
      chk("echo", ins, u_host.rep[3]);
      if (ev !== vx)
        chk("value", ev, {u_host.rep[4], u_host.rep[5], u_host.rep[6],
          u_host.rep[7]});
    end
  endtask
  task rw(input [3:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task rr(input [3:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      r = reg_rdata;
    end
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk("pullup", 1'b1, pullup_en);
    rr(`MIOC_REG_ACC);
    chk("acc", 1'b0, r);
    rr(4'h2);
    chk("unmapped", 1'b0, r);
    $display("reset test done");
    cmd(`MIOC_INSTR_RESTORE, 8'h2A, `MIOC_BANK_2, 0, 8'h64, 0);
    cmd(`MIOC_INSTR_RESTORE, 8'h2A, `MIOC_BANK_0, 0, 8'h04, vx);
    chk("restores", 1'b1, n_rest);
    chk("index", 8'h2A, rst_idx);
    for (i = 0; i < 2; i = i + 1)
      cmd(`MIOC_INSTR_HOMING, i, 8'h00, 0, `MIOC_ST_OK, vx);
    cmd(`MIOC_INSTR_HOMING, 8'h03, 8'h00, 0, 8'h03, vx);
    cmd(8'h10, 8'h00, 8'h00, 0, 8'h02, vx);
    chk("starts", 1'b1, n_start);
    chk("stops", 1'b1, n_stop);
    for (i = 0; i < 2; i = i + 1) begin
      homing_busy <= i;
      cmd(`MIOC_INSTR_HOMING, 8'h02, 8'h00, 0, `MIOC_ST_OK, i);
    end
    $display("restore and homing tests done");
    for (i = 0; i < 5; i = i + 1) begin
      cmd(`MIOC_INSTR_SETOUT, sp[8*(4-i) +: 8], `MIOC_BANK_2,
        sv[8*(4-i) +: 8], `MIOC_ST_OK, vx);
      chk("outs", se[2*(4-i) +: 2], {out_b, out_a});
    end
    cmd(`MIOC_INSTR_SETOUT, 8'h00, `MIOC_BANK_2, 2, 8'h04, vx);
    chk("outs", 2'b01, {out_b, out_a});
    rw(`MIOC_REG_ACC, 32'h0000_0003);
    cmd(`MIOC_INSTR_SETOUT, 8'hFF, `MIOC_BANK_2, -1, 8'h64, vx);
    chk("outs", 2'b11, {out_b, out_a});
    for (i = 0; i < 2; i = i + 1) begin
      cmd(`MIOC_INSTR_SETOUT, 8'h00, `MIOC_BANK_0, i, 8'h64, vx);
      chk("pullup", i, pullup_en);
    end
    $display("output tests done");
    for (i = 0; i < 5; i = i + 1)
      cmd(`MIOC_INSTR_READ, i, `MIOC_BANK_0, 0, 8'h64, gen_in[i]);
    for (i = 0; i < 4; i = i + 1)
      cmd(`MIOC_INSTR_READ, i < 2 ? 4 * i : 6 + i,
        `MIOC_BANK_1, 0, `MIOC_ST_OK, av[32*(3-i) +: 32]);
    cmd(`MIOC_INSTR_READ, 8'h01, `MIOC_BANK_2, 0, `MIOC_ST_OK, 1);
    cmd(`MIOC_INSTR_READ, 8'h00, 8'h03, 0, 8'h04, vx);
    rr(`MIOC_REG_ACC);
    chk("acc", 32'h0000_0003, r);
    @(posedge ref_clk);
    chk("rd idle", 32'h0000_0000, reg_rdata);
    cmd(`MIOC_INSTR_READ, 8'hFF, `MIOC_BANK_0, 0, 8'h64, 5'h16);
    rr(`MIOC_REG_ACC);
    chk("acc", 8'h16, r[7:0]);
    rw(`MIOC_REG_CTRL, 32'h0000_0001);
    rr(`MIOC_REG_CTRL);
    chk("ctrl", 32'h0000_0001, r);
    cmd(`MIOC_INSTR_READ, 8'h04, `MIOC_BANK_1, 0, 8'h64, 12'hFFF);
    rr(`MIOC_REG_ACC);
    chk("acc", 32'h0000_0FFF, r);
    $display("read tests done");
    u_host.send(`MIOC_ADDR_MODULE, 8'h0E, 8'h00, 8'h02, 0, 8'h5A);
    u_host.recv;
    chk("status", `MIOC_ST_BAD_CSUM, u_host.rep[2]);
    rr(`MIOC_REG_ERRCNT);
    chk("errcnt", 32'h0000_0001, r);
    u_host.send(8'h05, 8'h0E, 8'h00, 8'h02, 0, 8'h00);
    u_host.slow = 1'b1;
    cmd(`MIOC_INSTR_READ, 8'h00, `MIOC_BANK_2, 0, 8'h64, 1);
    cmd(`MIOC_INSTR_SETOUT, 8'h00, `MIOC_BANK_0, 0, 8'h64, vx);
    rr(`MIOC_REG_IO);
    chk("io", 32'h0000_000B, r);
    nrst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk("pullup", 1'b1, pullup_en);
    chk("outs", 2'b00, {out_b, out_a});
    rr(`MIOC_REG_CTRL);
    chk("ctrl", 32'h0000_0000, r);
    $display("frame and reset tests done");
    tally_and_finish;
  end
endmodule // testbench
